/* File: src/mesf_pkg.sv */
// Package: constants for the metering event status flag word
package mesf_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] EVENT_FLAG_WORD_ONE_ADDR = 16'h0403; // Flag word address
  localparam logic [31:0] EVENT_FLAG_WORD_ONE_RST = 32'h0000_0000; // Reset value
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHK_DONE_BIT = 27;
  localparam int CHK_CHG_BIT = 26;
  localparam int DIP_LSB = 23; // Phases A..C at 23..25
  localparam int SURGE_LSB = 20; // Phases A..C at 20..22
  localparam int RSVD_BIT = 19;
  localparam int SEQ_ERR_BIT = 18;
  localparam int OVC_BIT = 17;
  localparam int RST_DONE_BIT = 16;
  localparam int ICROSS_LSB = 13; // Phases A..C at 13..15
  localparam int COMB_BIT = 12;
  localparam int VCROSS_LSB = 9; // Phases A..C at 9..11
  localparam int TMO_LSB = 6; // Phases A..C at 6..8
  localparam int NOLOAD_BIT = 5;
  localparam int FLAG_LSB = 5;
  localparam int FLAG_MSB = 27;
  localparam int NUM_FLAGS = FLAG_MSB - FLAG_LSB + 1;
  // Mask of implemented sticky bits; bit 19 is reserved
  localparam logic [31:0] FLAG_MASK = 32'h0ff7_ffe0;
  // ----------------------------------------------------------------
  // Checksum engine
  // ----------------------------------------------------------------
  localparam int CHK_CYCLES = 32; // Cycles one checksum pass takes
  typedef enum logic [1:0] {
    MESF_CHK_IDLE = 2'b00,
    MESF_CHK_RUN = 2'b01,
    MESF_CHK_DONE = 2'b10
  } mesf_chk_state_e;
endpackage

/* File: src/mesf_sticky.sv */
// Module: one sticky event flag with write-one-to-clear
`timescale 1ns/1ps
module mesf_sticky (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Event and clear
  input wire logic i_set,
  input wire logic i_clr,
  // Flag
  output logic o_flag
);
  // Set wins over a clear landing in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end
endmodule

/* File: src/mesf_top.sv */
// Module: event flag word one with checksum sequencer and register access
`timescale 1ns/1ps
module mesf_top
  import mesf_pkg::*;
#(
  parameter int CHK_LEN = CHK_CYCLES // Checksum pass length in cycles
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register access from the serial port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Checksum control and data
  input wire logic i_force_checksum, // Force-update bit written
  input wire logic i_cfg_changed, // A covered register changed value
  input wire logic [31:0] i_checksum_value, // Running checksum of covered set
  output logic [31:0] o_checksum_result_register,
  output logic o_checksum_busy,
  // Power quality events, index 0 = phase A
  input wire logic [2:0] i_dip_edge,
  input wire logic [2:0] i_surge_edge,
  input wire logic i_seq_err,
  input wire logic [2:0] i_overcurrent,
  input wire logic i_powerup_done,
  input wire logic [2:0] i_current_cross,
  input wire logic i_comb_cross,
  input wire logic [2:0] i_voltage_cross,
  input wire logic [2:0] i_cross_timeout,
  input wire logic [2:0] i_noload_edge,
  // Phase detail registers
  output logic [2:0] o_overcurrent_phase_register,
  output logic [2:0] o_noload_phase_register,
  // Live flag word
  output logic [31:0] o_event_flag_word_one
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (CHK_LEN < 1 || CHK_LEN > 65535) begin : g_bad_len
    $error("CHK_LEN out of range");
  end

  // ----------------------------------------------------------------
  // Checksum sequencer
  // ----------------------------------------------------------------
  mesf_chk_state_e chk_state_ff; // Sequencer state
  logic [15:0] chk_cnt_ff; // Cycles remaining in pass
  logic chk_done_pulse; // One cycle at pass end
  logic chk_chg_pulse; // Checksum moved after a change

  // Force starts a pass; a force while busy is ignored
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      chk_state_ff <= MESF_CHK_IDLE;
      chk_cnt_ff <= 16'h0000;
    end else begin
      case (chk_state_ff)
        MESF_CHK_IDLE: begin
          if (i_force_checksum) begin
            chk_state_ff <= MESF_CHK_RUN;
            chk_cnt_ff <= 16'(CHK_LEN - 1);
          end
        end
        MESF_CHK_RUN: begin
          if (chk_cnt_ff == 16'h0000) begin
            chk_state_ff <= MESF_CHK_DONE;
          end else begin
            chk_cnt_ff <= chk_cnt_ff - 16'h0001;
          end
        end
        MESF_CHK_DONE: begin
          chk_state_ff <= MESF_CHK_IDLE;
        end
        default: begin
          chk_state_ff <= MESF_CHK_IDLE;
        end
      endcase
    end
  end

  assign chk_done_pulse = (chk_state_ff == MESF_CHK_DONE);

  // Change flag only when the stored result really differs
  assign chk_chg_pulse = i_cfg_changed && (i_checksum_value != o_checksum_result_register);

  // Result register follows a forced pass or a change
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_checksum_result_register <= 32'h0000_0000;
    end else if (chk_done_pulse || chk_chg_pulse) begin
      o_checksum_result_register <= i_checksum_value;
    end
  end

  // Busy mirrors the sequencer for the host side
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_checksum_busy <= 1'b0;
    end else begin
      o_checksum_busy <= (chk_state_ff == MESF_CHK_RUN) ||
                         (chk_state_ff == MESF_CHK_IDLE && i_force_checksum);
    end
  end

  // ----------------------------------------------------------------
  // Phase detail registers
  // ----------------------------------------------------------------
  logic wr_hit; // Write addressed to flag word

  // Decoded once here; the phase registers and the flag cells both need it
  assign wr_hit = i_reg_wr && (i_reg_addr == EVENT_FLAG_WORD_ONE_ADDR);

  // Phases accumulate until the matching flag is cleared
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_overcurrent_phase_register <= 3'h0;
    end else if (wr_hit && i_reg_wdata[OVC_BIT]) begin
      o_overcurrent_phase_register <= i_overcurrent;
    end else begin
      o_overcurrent_phase_register <= o_overcurrent_phase_register | i_overcurrent;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_noload_phase_register <= 3'h0;
    end else if (wr_hit && i_reg_wdata[NOLOAD_BIT]) begin
      o_noload_phase_register <= i_noload_edge;
    end else begin
      o_noload_phase_register <= o_noload_phase_register | i_noload_edge;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  logic [31:0] set_vec; // Event per bit position
  logic [31:0] flags; // Sticky flag outputs

  // Map events onto bit positions
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[CHK_DONE_BIT] = chk_done_pulse;
    set_vec[CHK_CHG_BIT] = chk_chg_pulse;
    set_vec[DIP_LSB +: 3] = i_dip_edge;
    set_vec[SURGE_LSB +: 3] = i_surge_edge;
    set_vec[SEQ_ERR_BIT] = i_seq_err;
    set_vec[OVC_BIT] = |i_overcurrent;
    set_vec[RST_DONE_BIT] = i_powerup_done;
    set_vec[ICROSS_LSB +: 3] = i_current_cross;
    set_vec[COMB_BIT] = i_comb_cross;
    set_vec[VCROSS_LSB +: 3] = i_voltage_cross;
    set_vec[TMO_LSB +: 3] = i_cross_timeout;
    set_vec[NOLOAD_BIT] = |i_noload_edge;
  end

  // One sticky cell per implemented bit; the rest stay zero
  genvar gi;
  for (gi = 0; gi < 32; gi++) begin : g_flag
    if (FLAG_MASK[gi]) begin : g_cell
      mesf_sticky u_cell (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_set(set_vec[gi]),
        .i_clr(wr_hit && i_reg_wdata[gi]),
        .o_flag(flags[gi])
      );
    end else begin : g_zero
      assign flags[gi] = 1'b0;
    end
  end

  // Live word registered so the output is a flop
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_event_flag_word_one <= EVENT_FLAG_WORD_ONE_RST;
    end else begin
      o_event_flag_word_one <= flags & FLAG_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped addresses read zero; data one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 32'h0000_0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd && i_reg_addr == EVENT_FLAG_WORD_ONE_ADDR) begin
        o_reg_rdata <= flags & FLAG_MASK;
      end else begin
        o_reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_pass_start;
    chk_state_ff == MESF_CHK_IDLE && i_force_checksum;
  endsequence

  // Last counted cycle of a pass; start and end are tied by the loaded count
  sequence s_pass_end;
    chk_state_ff == MESF_CHK_RUN && chk_cnt_ff == 16'h0000;
  endsequence

  chk_pass_sets_done: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_pass_end |=> chk_done_pulse ##1 flags[CHK_DONE_BIT])
    else $error("checksum done flag not set at pass end");
  chk_force_starts_run: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_pass_start |=> chk_state_ff == MESF_CHK_RUN && chk_cnt_ff == 16'(CHK_LEN - 1))
    else $error("force did not start checksum");
  chk_change_sets_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
    chk_chg_pulse |=> flags[CHK_CHG_BIT])
    else $error("checksum change flag not set");
  chk_result_updates: assert property (@(posedge i_core_clk) disable iff (i_rst)
    chk_chg_pulse |=> o_checksum_result_register == $past(i_checksum_value))
    else $error("checksum result not stored");
  chk_dip_sets_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_dip_edge[2] |=> ##1 o_event_flag_word_one[DIP_LSB + 2])
    else $error("dip flag phase c not set");
  chk_surge_sets_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_surge_edge[0] |=> flags[SURGE_LSB])
    else $error("surge flag phase a not set");
  chk_ovc_phase_kept: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_overcurrent[2] |=> flags[OVC_BIT] && o_overcurrent_phase_register[2])
    else $error("overcurrent flag or phase lost");
  chk_reset_done_flag_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_powerup_done |=> flags[RST_DONE_BIT])
    else $error("reset done flag not set");
  chk_clear_by_one: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wr_hit && i_reg_wdata[COMB_BIT] && !i_comb_cross |=> !flags[COMB_BIT])
    else $error("write one did not clear flag");
  chk_zero_keeps: assert property (@(posedge i_core_clk) disable iff (i_rst)
    flags[TMO_LSB] && !(wr_hit && i_reg_wdata[TMO_LSB]) |=> flags[TMO_LSB])
    else $error("flag lost without clear");
  chk_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_reg_rvalid |-> !o_reg_rdata[RSVD_BIT] && !o_event_flag_word_one[RSVD_BIT])
    else $error("reserved bit reads nonzero");
endmodule

/* File: tb/mesf_host_model.sv */
// Host model: serial-port master that reads, clears and starts checksums
`timescale 1ns/1ps
module mesf_host_model (
  // Clock
  input wire logic i_core_clk,
  // Requests toward the device
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [15:0] o_reg_addr,
  output logic [31:0] o_reg_wdata,
  output logic o_force_checksum,
  // Answers from the device
  input wire logic [31:0] i_reg_rdata,
  input wire logic i_reg_rvalid
);
  // Idle bus at time zero
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 16'h0000;
    o_reg_wdata = 32'h0000_0000;
    o_force_checksum = 1'b0;
  end
  // One-cycle write; released bus shows inverted values, never stale ones
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge i_core_clk);
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(negedge i_core_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
  // Read; ok only when the answer lands exactly one cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
    @(negedge i_core_clk);
    ok = (i_reg_rvalid === 1'b0);
    o_reg_rd = 1'b1;
    o_reg_addr = a;
    // Answer stands for the one cycle after the taking edge
    @(negedge i_core_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    ok = ok && (i_reg_rvalid === 1'b1);
    d = i_reg_rdata;
  endtask
  // Force-update bit written: starts a checksum pass
  task automatic force_checksum();
    @(negedge i_core_clk);
    o_force_checksum = 1'b1;
    @(negedge i_core_clk);
    o_force_checksum = 1'b0;
  endtask
  // Poll the reset-done flag before any configuration, bounded
  task automatic wait_ready(output logic ok);
    logic [31:0] d;
    logic v;
    ok = 1'b0;
    for (int n = 0; n < 16 && !ok; n++) begin
      rd(mesf_pkg::EVENT_FLAG_WORD_ONE_ADDR, d, v);
      ok = (d[16] === 1'b1);
    end
  endtask
endmodule

/* File: tb/mesf_top_tb_top.sv */
// Testbench: event flag word, sticky clears, reserved bit and checksum flags
`timescale 1ns/1ps
module mesf_top_tb_top;
  import mesf_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [31:0] evt = 32'h0000_0000; // Event pulses, laid out as flag bits
  logic cfg_chg = 1'b0;
  logic [31:0] chk_val = 32'h5a5a_1234;
  logic wr, rd, frc, rvalid, busy;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, chk_res, live;
  logic [2:0] oc_ph, nl_ph;
  int n_mismatch = 0;
  int comparisons = 0;
  always #2.5 i_core_clk = ~i_core_clk;
  // Short checksum pass keeps the run brief
  mesf_top #(.CHK_LEN(2)) dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_force_checksum(frc), .i_cfg_changed(cfg_chg), .i_checksum_value(chk_val),
    .o_checksum_result_register(chk_res), .o_checksum_busy(busy), .i_dip_edge(evt[25:23]),
    .i_surge_edge(evt[22:20]), .i_seq_err(evt[18]), .i_overcurrent({evt[17], 2'b00}),
    .i_powerup_done(evt[16]), .i_current_cross(evt[15:13]), .i_comb_cross(evt[12]),
    .i_voltage_cross(evt[11:9]), .i_cross_timeout(evt[8:6]), .i_noload_edge({2'b00, evt[5]}),
    .o_overcurrent_phase_register(oc_ph), .o_noload_phase_register(nl_ph), .o_event_flag_word_one(live));
  mesf_host_model host_u (.i_core_clk(i_core_clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .o_force_checksum(frc), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid));
  // ----------------------------------------------------------------
  // Shared checking
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Read the flag word and compare, answer timing included
  task automatic read_expect(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    host_u.rd(a, d, ok);
    check("read answer timing", {31'h0, ok}, 32'h1);
    check("read data", d, exp);
  endtask
  // One-cycle event pulse on the given flag position
  task automatic pulse(input int b);
    @(negedge i_core_clk);
    evt[b] = 1'b1;
    @(negedge i_core_clk);
    evt[b] = 1'b0;
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset-done flag sets, host waits for it, then clears it
  task automatic scen_powerup();
    logic ok;
    read_expect(EVENT_FLAG_WORD_ONE_ADDR, 32'h0);
    pulse(RST_DONE_BIT);
    host_u.wait_ready(ok);
    check("reset done seen", {31'h0, ok}, 32'h1);
    if (ok !== 1'b1) report_and_stop();
    host_u.wr(EVENT_FLAG_WORD_ONE_ADDR, 32'h0001_0000);
    read_expect(EVENT_FLAG_WORD_ONE_ADDR, 32'h0);
  endtask
  // Every event source at bits 5 to 25 sets only its own bit; zero write keeps, one clears
  task automatic scen_events();
    for (int b = FLAG_LSB; b <= DIP_LSB + 2; b++) begin
      if (b == RSVD_BIT) continue;
      pulse(b);
      read_expect(EVENT_FLAG_WORD_ONE_ADDR, 32'h1 << b);
      check("live word", live, 32'h1 << b);
      if (b == OVC_BIT) check("overcurrent phases", {29'h0, oc_ph}, 32'h4);
      if (b == NOLOAD_BIT) check("noload phases", {29'h0, nl_ph}, 32'h1);
      host_u.wr(EVENT_FLAG_WORD_ONE_ADDR, ~(32'h1 << b));
      read_expect(EVENT_FLAG_WORD_ONE_ADDR, 32'h1 << b);
      host_u.wr(EVENT_FLAG_WORD_ONE_ADDR, 32'h1 << b);
      read_expect(EVENT_FLAG_WORD_ONE_ADDR, 32'h0);
    end
  endtask
  // Other addresses do not clear and answer with zero data; reserved bit stays zero
  task automatic scen_unmapped();
    pulse(COMB_BIT);
    host_u.wr(EVENT_FLAG_WORD_ONE_ADDR + 16'h1, 32'hffff_ffff);
    read_expect(EVENT_FLAG_WORD_ONE_ADDR + 16'h1, 32'h0);
    read_expect(EVENT_FLAG_WORD_ONE_ADDR, 32'h0000_1000);
    host_u.wr(EVENT_FLAG_WORD_ONE_ADDR, 32'hffff_ffff);
    read_expect(EVENT_FLAG_WORD_ONE_ADDR, 32'h0);
  endtask
  // Forced pass ends with the done flag; a changed checksum sets the change flag
  task automatic scen_checksum();
    int n;
    host_u.force_checksum();
    check("checksum busy", {31'h0, busy}, 32'h1);
    for (n = 0; n < 20 && busy !== 1'b0; n++) @(negedge i_core_clk);
    if (n == 20) begin
      check("checksum pass ends", 32'h0, 32'h1);
      report_and_stop();
    end
    repeat (3) @(posedge i_core_clk);
    read_expect(EVENT_FLAG_WORD_ONE_ADDR, 32'h0800_0000);
    check("checksum result", chk_res, 32'h5a5a_1234);
    host_u.wr(EVENT_FLAG_WORD_ONE_ADDR, 32'h0800_0000);
    @(negedge i_core_clk);
    chk_val = 32'h0f0f_00f0;
    cfg_chg = 1'b1;
    @(negedge i_core_clk);
    cfg_chg = 1'b0;
    repeat (3) @(posedge i_core_clk);
    read_expect(EVENT_FLAG_WORD_ONE_ADDR, 32'h0400_0000);
    check("checksum new result", chk_res, 32'h0f0f_00f0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge i_core_clk);
    i_rst = 1'b0;
    scen_powerup();
    scen_events();
    scen_unmapped();
    scen_checksum();
    report_and_stop();
  end
endmodule
